// ==== pkg/msd_pkg.sv ====
package msd_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;

   // register offsets inside the control block
   localparam logic [7:0] OFS_UPPER_CTRL = 8'ha0;
   localparam logic [7:0] OFS_LOWER_CTRL = 8'ha2;
   localparam logic [7:0] OFS_MID_BASE   = 8'ha6;
   localparam logic [7:0] OFS_MID_SIZE   = 8'ha8;
   localparam logic [7:0] OFS_CTRL_BASE  = 8'hfe;

   // values after reset
   localparam logic [15:0] RST_UPPER_CTRL = 16'hfffb;
   localparam logic [15:0] RST_CTRL_BASE  = 16'h20ff;
   localparam logic [15:0] RST_OTHER_CTRL = 16'h0000;

   // field positions
   localparam int BLOCK_LSB      = 8;
   localparam int BIT_MEM_SPACE  = 12;
   localparam int BIT_ESC_TRAP   = 13;
   localparam int BIT_SLAVE_MODE = 14;
   localparam int LIMIT_LSB      = 6;
   localparam int RDY_IGNORE_BIT = 2;
   localparam int MID_BASE_LSB   = 9;
   localparam int MID_SIZE_LSB   = 8;
   localparam int MID_SIZE_W     = 7;
   localparam int QUARTER_LSB    = 11;
   localparam int MID_ADDR_LSB   = 13;

   localparam logic [2:0] RDY_DEFAULT  = 3'h0;
   localparam logic [2:0] RDY_INTERNAL = 3'h4;
endpackage

// ==== src/msd_cs_decode.sv ====
`timescale 1ns/1ps
module msd_cs_decode
   import msd_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              mem_i,
   input  wire logic [15:0]       upper_ctrl_i,
   input  wire logic [15:0]       lower_ctrl_i,
   input  wire logic [15:0]       mid_base_i,
   input  wire logic [15:0]       mid_size_i,
   input  wire logic              lower_en_i,
   input  wire logic              mid_en_i,
   output logic                   up_hit_o,
   output logic                   lo_hit_o,
   output logic [3:0]             mid_hit_o
);
   logic [MID_SIZE_W-1:0] size;
   logic [MID_SIZE_W-1:0] span;
   logic [1:0]            quarter;
   logic                  in_mid;

   always_comb begin
      size = mid_size_i[MID_SIZE_LSB +: MID_SIZE_W];
      span = size - 7'h01;
      // upper limit fixed at top, lower bits of limit read as zero
      up_hit_o = mem_i &&
         addr_i[19:4] >= {upper_ctrl_i[15:LIMIT_LSB], 6'h00};
      // bottom fixed at zero, lower bits of limit read as ones
      lo_hit_o = mem_i && lower_en_i &&
         addr_i[19:4] <= {lower_ctrl_i[15:LIMIT_LSB], 6'h3f};
      // an empty size field never hits, so a cleared field is harmless
      in_mid = mem_i && mid_en_i && size != '0 &&
         ((addr_i[19:MID_ADDR_LSB] ^ mid_base_i[15:MID_BASE_LSB])
          & ~span) == '0;
      quarter = 2'h0;
      for (int n = 0; n < MID_SIZE_W; n++) begin
         if (size[n]) begin
            quarter = addr_i[QUARTER_LSB + n +: 2];
         end
      end
      mid_hit_o = in_mid ? 4'h1 << quarter : 4'h0;
   end
endmodule

// ==== src/msd_ready_gen.sv ====
`timescale 1ns/1ps
module msd_ready_gen
   import msd_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [1:0] waits_i,
   input  wire logic       ignore_i,
   input  wire logic       ext_ready_i,
   output logic            done_o
);
   typedef struct packed {
      logic [1:0] cnt;
      logic       ign;
      logic       busy;
      logic       done;
   } msd_rdy_state_t;

   msd_rdy_state_t s_q;
   msd_rdy_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (start_i) begin
         s_d.cnt  = waits_i;
         s_d.ign  = ignore_i;
         s_d.busy = 1'b1;
         s_d.done = 1'b0;
      end else if (s_q.busy) begin
         if (s_q.cnt != 2'h0) begin
            s_d.cnt = s_q.cnt - 2'h1;
         end else if (s_q.ign || ext_ready_i) begin
            // external ready is only sampled once the internal waits have run out
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done_o = s_q.done;

   // a start in the next clock restarts the count, so it is excluded
   AST_RDY_ZERO_WAIT: assert property (
      @(posedge clock_i) disable iff (rst_i)
      start_i && ignore_i && waits_i == 2'h0 ##1 !start_i
      |-> !done_o ##1 done_o)
      else $error("zero wait cycle not ready on time");
   AST_RDY_THREE_WAIT: assert property (
      @(posedge clock_i) disable iff (rst_i)
      start_i && ignore_i && waits_i == 2'h3 ##1 !start_i [*4]
      |-> !done_o ##1 done_o)
      else $error("three wait cycle ready at wrong time");
endmodule

// ==== src/msd_select_decode.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - peripheral registers are 16-bit inside a 256-byte control block
// - internal cycles still run on the bus but ignore ready inputs
// - control block base sits on a 256-byte boundary
// - relocation register at offset FEH gives upper 12 base bits
// - relocation bit 12 picks memory space, else I/O space
// - relocation register also holds slave-mode and escape-trap bits
// - relocation register resets to 20FFH, block at FF00H in I/O
// - selects assert for any master's cycle in range, core or DMA
// - six memory selects: one upper, one lower, four mid-range
// - sizes 2K to 128K in powers of two, plus 1K and 256K
// - upper select tops at FFFFFH, upper limit in register A0H
// - upper hits when address bits 19-4 reach limit, low bits zero
// - upper select covers a 1K top block after reset
// - lower select at A2H hits up to limit, low bits as ones
// - lower select stays off until its register is accessed
// - upper, lower and mid base registers carry a three-bit ready mode
// - mid size from bits 8-14 of register A8H
// - exactly one mid size bit set, 8K up to 512K
// - mid block split into four quarters, lowest to first line
// - ready mode top bit ignores external ready, low bits waits
// - upper register resets to FFFBH: 1K, three waits, ready used
// - mid base from register A6H bits 15-9 as address 19-13
// - mid selects off until base and size registers accessed
module msd_select_decode
   import msd_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              cyc_start_i,
   input  wire logic              cyc_end_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              mem_space_i,
   input  wire logic              write_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              async_ready_in_i,
   input  wire logic              sync_ready_in_i,
   output logic [DATA_W-1:0]      rdata_o,
   output logic                   internal_hit_o,
   output logic                   ignore_ready_o,
   output logic [1:0]             wait_states_o,
   output logic                   cycle_ready_o,
   output logic                   upper_area_select_n_o,
   output logic                   lower_area_select_n_o,
   output logic [3:0]             mid_area_selects_n_o,
   output logic                   alternate_slave_mode_o,
   output logic                   escape_opcode_trap_o
);
   typedef struct packed {
      logic [15:0] upper_ctrl;
      logic [15:0] lower_ctrl;
      logic [15:0] mid_base;
      logic [15:0] mid_size;
      logic [15:0] ctrl_base;
      logic        lower_seen;
      logic        base_seen;
      logic        size_seen;
      logic        internal;
      logic        ign;
      logic [1:0]  waits;
      logic [15:0] rdata;
      logic        up_n;
      logic        lo_n;
      logic [3:0]  mid_n;
   } msd_state_t;

   msd_state_t s_q;
   msd_state_t s_d;

   logic       up_hit;
   logic       lo_hit;
   logic [3:0] mid_hit;
   logic       blk_hit;
   logic [2:0] mode;
   logic       ext_ready;

   function automatic logic [15:0] reg_read(input logic [7:0] ofs,
                                            input msd_state_t st);
      logic [15:0] v;
      v = 16'h0000;
      case (ofs)
         OFS_UPPER_CTRL: v = st.upper_ctrl;
         OFS_LOWER_CTRL: v = st.lower_ctrl;
         OFS_MID_BASE:   v = st.mid_base;
         OFS_MID_SIZE:   v = st.mid_size;
         OFS_CTRL_BASE:  v = st.ctrl_base;
         default:        v = 16'h0000;
      endcase
      return v;
   endfunction

   msd_cs_decode u_decode (
      .addr_i       (addr_i),
      .mem_i        (mem_space_i),
      .upper_ctrl_i (s_q.upper_ctrl),
      .lower_ctrl_i (s_q.lower_ctrl),
      .mid_base_i   (s_q.mid_base),
      .mid_size_i   (s_q.mid_size),
      .lower_en_i   (s_q.lower_seen),
      .mid_en_i     (s_q.base_seen && s_q.size_seen),
      .up_hit_o     (up_hit),
      .lo_hit_o     (lo_hit),
      .mid_hit_o    (mid_hit)
   );

   // one address port serves both core and DMA, so both decode alike
   always_comb begin
      // low eight base bits are implied zero by the compare width
      blk_hit = addr_i[19:BLOCK_LSB] == s_q.ctrl_base[11:0]
         && mem_space_i == s_q.ctrl_base[BIT_MEM_SPACE];
      if (blk_hit) begin
         mode = RDY_INTERNAL;
      end else if (up_hit) begin
         mode = s_q.upper_ctrl[2:0];
      end else if (lo_hit) begin
         mode = s_q.lower_ctrl[2:0];
      end else if (mid_hit != 4'h0) begin
         mode = s_q.mid_base[2:0];
      end else begin
         mode = RDY_DEFAULT;
      end
   end

   always_comb begin
      s_d = s_q;
      if (cyc_end_i) begin
         s_d.up_n     = 1'b1;
         s_d.lo_n     = 1'b1;
         s_d.mid_n    = 4'hf;
         s_d.internal = 1'b0;
         s_d.ign      = 1'b0;
         s_d.waits    = 2'h0;
      end
      if (cyc_start_i) begin
         // a new cycle wins over an end in the same clock
         s_d.up_n     = ~up_hit;
         s_d.lo_n     = ~lo_hit;
         s_d.mid_n    = ~mid_hit;
         s_d.internal = blk_hit;
         s_d.ign      = mode[RDY_IGNORE_BIT];
         s_d.waits    = mode[1:0];
         if (blk_hit) begin
            if (!write_i) begin
               s_d.rdata = reg_read(addr_i[7:0], s_q);
            end
            case (addr_i[7:0])
               OFS_UPPER_CTRL: begin
                  if (write_i) begin
                     s_d.upper_ctrl = wdata_i;
                  end
               end
               OFS_LOWER_CTRL: begin
                  s_d.lower_seen = 1'b1;
                  if (write_i) begin
                     s_d.lower_ctrl = wdata_i;
                  end
               end
               OFS_MID_BASE: begin
                  s_d.base_seen = 1'b1;
                  if (write_i) begin
                     s_d.mid_base = wdata_i;
                  end
               end
               OFS_MID_SIZE: begin
                  s_d.size_seen = 1'b1;
                  if (write_i) begin
                     s_d.mid_size = wdata_i;
                  end
               end
               OFS_CTRL_BASE: begin
                  if (write_i) begin
                     s_d.ctrl_base = wdata_i;
                  end
               end
               default: begin
                  s_d.rdata = s_d.rdata;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_q            <= '0;
         s_q.upper_ctrl <= RST_UPPER_CTRL;
         s_q.lower_ctrl <= RST_OTHER_CTRL;
         s_q.mid_base   <= RST_OTHER_CTRL;
         s_q.mid_size   <= RST_OTHER_CTRL;
         s_q.ctrl_base  <= RST_CTRL_BASE;
         s_q.up_n       <= 1'b1;
         s_q.lo_n       <= 1'b1;
         s_q.mid_n      <= 4'hf;
      end else begin
         s_q <= s_d;
      end
   end

   // external ready is level-synchronous here; either input releases
   assign ext_ready = async_ready_in_i || sync_ready_in_i;

   msd_ready_gen u_ready (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .start_i     (cyc_start_i),
      .waits_i     (mode[1:0]),
      .ignore_i    (mode[RDY_IGNORE_BIT]),
      .ext_ready_i (ext_ready),
      .done_o      (cycle_ready_o)
   );

   assign rdata_o                = s_q.rdata;
   assign internal_hit_o         = s_q.internal;
   assign ignore_ready_o         = s_q.ign;
   assign wait_states_o          = s_q.waits;
   assign upper_area_select_n_o  = s_q.up_n;
   assign lower_area_select_n_o  = s_q.lo_n;
   assign mid_area_selects_n_o   = s_q.mid_n;
   assign alternate_slave_mode_o = s_q.ctrl_base[BIT_SLAVE_MODE];
   assign escape_opcode_trap_o   = s_q.ctrl_base[BIT_ESC_TRAP];

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   AST_BLOCK_HIT: assert property (
      cyc_start_i && addr_i[19:8] == s_q.ctrl_base[11:0]
      && mem_space_i == s_q.ctrl_base[BIT_MEM_SPACE] |=> internal_hit_o)
      else $error("control block access not recognised");
   AST_BLOCK_SPACE: assert property (
      cyc_start_i && mem_space_i != s_q.ctrl_base[BIT_MEM_SPACE]
      |=> !internal_hit_o)
      else $error("control block hit in wrong space");
   AST_INTERNAL_IGNORE: assert property (
      internal_hit_o |-> ignore_ready_o && wait_states_o == 2'h0)
      else $error("internal cycle does not ignore ready");
   AST_LOWER_LOCK: assert property (
      !s_q.lower_seen |-> lower_area_select_n_o)
      else $error("lower select active before access");
   AST_MID_LOCK: assert property (
      !(s_q.base_seen && s_q.size_seen) |-> mid_area_selects_n_o == 4'hf)
      else $error("mid select active before access");
   AST_UPPER_RANGE: assert property (
      cyc_start_i && mem_space_i
      && addr_i[19:4] >= {s_q.upper_ctrl[15:6], 6'h00}
      |=> !upper_area_select_n_o)
      else $error("upper select missed its range");
   AST_LOWER_RANGE: assert property (
      cyc_start_i && mem_space_i && s_q.lower_seen
      && addr_i[19:4] > {s_q.lower_ctrl[15:6], 6'h3f}
      |=> lower_area_select_n_o)
      else $error("lower select beyond its limit");
   AST_CS_RELEASE: assert property (
      cyc_end_i && !cyc_start_i |=> upper_area_select_n_o
      && lower_area_select_n_o && mid_area_selects_n_o == 4'hf)
      else $error("select held after cycle end");
   AST_MID_ONE_LINE: assert property (
      $onehot0(~mid_area_selects_n_o))
      else $error("more than one mid select active");
   AST_MODE_HOLD: assert property (
      !cyc_start_i && !cyc_end_i |=> $stable(wait_states_o)
      && $stable(ignore_ready_o))
      else $error("ready mode changed inside a cycle");

   // select range checks, both sides of each limit
   AST_UPPER_BELOW: assert property (
      cyc_start_i && mem_space_i
      && addr_i[19:4] < {s_q.upper_ctrl[15:6], 6'h00}
      |=> upper_area_select_n_o)
      else $error("upper select below its limit");

   AST_LOWER_HIT: assert property (
      cyc_start_i && mem_space_i && s_q.lower_seen
      && addr_i[19:4] <= {s_q.lower_ctrl[15:6], 6'h3f}
      |=> !lower_area_select_n_o)
      else $error("lower select missed its range");

   // memory selects stay quiet on I/O cycles
   AST_IO_NO_SELECT: assert property (
      cyc_start_i && !mem_space_i
      |=> upper_area_select_n_o && lower_area_select_n_o
      && mid_area_selects_n_o == 4'hf)
      else $error("memory select on an I/O cycle");

   // mid checks pinned to one block size to keep the compare plain
   AST_MID_QUARTER: assert property (
      cyc_start_i && mem_space_i && s_q.base_seen && s_q.size_seen
      && s_q.mid_size[14:8] == 7'h04
      && addr_i[19:15] == s_q.mid_base[15:11]
      |=> mid_area_selects_n_o == ~(4'h1 << $past(addr_i[14:13])))
      else $error("wrong mid line for a 32K block");

   AST_MID_OUTSIDE: assert property (
      cyc_start_i && s_q.mid_size[14:8] == 7'h04
      && addr_i[19:15] != s_q.mid_base[15:11]
      |=> mid_area_selects_n_o == 4'hf)
      else $error("mid select outside its block");

   AST_UPPER_MODE: assert property (
      cyc_start_i && !blk_hit && mem_space_i
      && addr_i[19:4] >= {s_q.upper_ctrl[15:6], 6'h00}
      |=> wait_states_o == $past(s_q.upper_ctrl[1:0])
      && ignore_ready_o == $past(s_q.upper_ctrl[RDY_IGNORE_BIT]))
      else $error("upper ready mode not applied");

   // register file: read path, relocation write and access latches
   AST_READ_BASE: assert property (
      cyc_start_i && blk_hit && !write_i && addr_i[7:0] == OFS_CTRL_BASE
      |=> rdata_o == $past(s_q.ctrl_base))
      else $error("relocation register read back wrong");

   AST_RELOC_WRITE: assert property (
      cyc_start_i && blk_hit && write_i && addr_i[7:0] == OFS_CTRL_BASE
      |=> alternate_slave_mode_o == $past(wdata_i[BIT_SLAVE_MODE])
      && escape_opcode_trap_o == $past(wdata_i[BIT_ESC_TRAP]))
      else $error("relocation mode bits not taken");

   AST_LOWER_SEEN: assert property (
      cyc_start_i && blk_hit && addr_i[7:0] == OFS_LOWER_CTRL
      |=> s_q.lower_seen)
      else $error("lower register access not latched");

   AST_MID_SEEN: assert property (
      cyc_start_i && blk_hit && addr_i[7:0] == OFS_MID_SIZE
      |=> s_q.size_seen)
      else $error("mid size access not latched");

   // ready is never left over from the previous cycle
   AST_READY_CLEAR: assert property (
      cyc_start_i |=> !cycle_ready_o)
      else $error("ready carried into a new cycle");

   AST_INTERNAL_READY: assert property (
      cyc_start_i && blk_hit ##1 !cyc_start_i |=> cycle_ready_o)
      else $error("internal cycle waited on external ready");

   COV_INTERNAL_WRITE: cover property (
      cyc_start_i && write_i ##1 internal_hit_o);
   COV_UPPER_CYCLE: cover property (
      !upper_area_select_n_o ##[1:8] cycle_ready_o);
   COV_MID_CYCLE: cover property (mid_area_selects_n_o != 4'hf);
   COV_LOWER_CYCLE: cover property (!lower_area_select_n_o);
   COV_THREE_WAIT: cover property (
      wait_states_o == 2'h3 && ignore_ready_o);
endmodule

// ==== verification/msd_mem_model.sv ====
`timescale 1ns/1ps
module msd_mem_model (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       slow_i,
   input  wire logic [3:0] delay_i,
   input  wire logic       upper_area_select_n_i,
   input  wire logic       lower_area_select_n_i,
   input  wire logic [3:0] mid_area_selects_n_i,
   output logic            async_ready_o,
   output logic            sync_ready_o
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       rdy;
   } msd_mdl_state_t;

   msd_mdl_state_t st_q;
   msd_mdl_state_t st_d;
   logic           picked;

   assign picked = !upper_area_select_n_i || !lower_area_select_n_i
                   || (mid_area_selects_n_i != 4'hf);
   // prompt memories keep the async line up; slow ones count first
   assign async_ready_o = !slow_i;
   assign sync_ready_o  = st_q.rdy;

   always_comb begin
      st_d = '0;
      if (picked && slow_i) begin
         st_d.cnt = (st_q.cnt == 4'hf) ? st_q.cnt : st_q.cnt + 4'h1;
         st_d.rdy = ({1'b0, st_q.cnt} + 5'h01) >= {1'b0, delay_i};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// ==== verification/msd_select_decode_tb.sv ====
`timescale 1ns/1ps
module msd_select_decode_tb;
   import msd_pkg::*;
   typedef struct packed {
      logic [19:0] a;
      logic        m;
      logic        w;
      logic [15:0] d;
      logic [5:0]  sel;
      logic        ih;
      logic        ig;
      logic [1:0]  ws;
      logic [15:0] rd;
   } msd_row_t;

   logic              clock_i     = 1'b0;
   logic              rst_i       = 1'b1;
   logic              cyc_start_i = 1'b0;
   logic              cyc_end_i   = 1'b0;
   logic [ADDR_W-1:0] addr_i      = '0;
   logic              mem_space_i = 1'b0;
   logic              write_i     = 1'b0;
   logic [DATA_W-1:0] wdata_i     = '0;
   logic              slow        = 1'b0;
   logic              async_rdy;
   logic              sync_rdy;
   logic [DATA_W-1:0] rdata_o;
   logic              internal_hit_o;
   logic              ignore_ready_o;
   logic [1:0]        wait_states_o;
   logic              cycle_ready_o;
   logic              up_n;
   logic              lo_n;
   logic [3:0]        mid_n;
   logic              slave;
   logic              trap;
   int                fails  = 0;
   int                checks = 0;
   msd_row_t          rows [27];

   always #4 clock_i = ~clock_i;

   msd_select_decode u_msd_select_decode (
      .clock_i(clock_i), .rst_i(rst_i), .cyc_start_i(cyc_start_i),
      .cyc_end_i(cyc_end_i), .addr_i(addr_i), .mem_space_i(mem_space_i),
      .write_i(write_i), .wdata_i(wdata_i), .async_ready_in_i(async_rdy),
      .sync_ready_in_i(sync_rdy), .rdata_o(rdata_o),
      .internal_hit_o(internal_hit_o), .ignore_ready_o(ignore_ready_o),
      .wait_states_o(wait_states_o), .cycle_ready_o(cycle_ready_o),
      .upper_area_select_n_o(up_n), .lower_area_select_n_o(lo_n),
      .mid_area_selects_n_o(mid_n), .alternate_slave_mode_o(slave),
      .escape_opcode_trap_o(trap));

   msd_mem_model u_msd_mem_model (
      .clock_i(clock_i), .rst_i(rst_i), .slow_i(slow), .delay_i(4'h6),
      .upper_area_select_n_i(up_n), .lower_area_select_n_i(lo_n),
      .mid_area_selects_n_i(mid_n), .async_ready_o(async_rdy),
      .sync_ready_o(sync_rdy));

   task automatic report_and_stop();
      if (fails == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [19:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic msd_row_t mk(int a, int m, int w, int d, int sel,
      int ih, int ig, int ws, int rd);
      return '{20'(a), 1'(m), 1'(w), 16'(d), 6'(sel), 1'(ih), 1'(ig),
               2'(ws), 16'(rd)};
   endfunction

   // one whole bus cycle: start, answer, completion, end
   task automatic do_row(input msd_row_t r, input logic [19:0] en);
      int n;
      @(posedge clock_i);
      cyc_start_i <= 1'b1;
      addr_i <= r.a;
      mem_space_i <= r.m;
      write_i <= r.w;
      wdata_i <= r.d;
      @(posedge clock_i);
      cyc_start_i <= 1'b0;
      #1;
      chk("selects", 20'({up_n, lo_n, mid_n}), 20'(r.sel));
      chk("internal", 20'(internal_hit_o), 20'(r.ih));
      chk("ignore", 20'(ignore_ready_o), 20'(r.ig));
      chk("waits", 20'(wait_states_o), 20'(r.ws));
      if (!r.w && r.ih) chk("rdata", 20'(rdata_o), 20'(r.rd));
      n = 1;
      while (cycle_ready_o !== 1'b1 && n < 30) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      chk("cycles", 20'(n), en);
      @(posedge clock_i);
      cyc_end_i <= 1'b1;
      @(posedge clock_i);
      cyc_end_i <= 1'b0;
      #1;
      chk("idle", 20'({up_n, lo_n, mid_n, internal_hit_o}), 20'h7e);
   endtask

   initial begin
      #160000;
      fails++;
      report_and_stop();
   end

   initial begin
      rows[0]  = mk(20'h0fffe, 0, 0, 0, 6'h3f, 1, 1, 0, 16'h20ff);
      rows[1]  = mk(20'h0ffa0, 0, 0, 0, 6'h3f, 1, 1, 0, 16'hfffb);
      rows[2]  = mk(20'hffff0, 1, 0, 0, 6'h1f, 0, 0, 3, 0);
      rows[3]  = mk(20'hffc00, 1, 0, 0, 6'h1f, 0, 0, 3, 0);
      rows[4]  = mk(20'hffbff, 1, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[5]  = mk(20'h00010, 1, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[6]  = mk(20'h0ffa2, 0, 1, 16'h007d, 6'h3f, 1, 1, 0, 0);
      rows[7]  = mk(20'h007ff, 1, 0, 0, 6'h2f, 0, 1, 1, 0);
      rows[8]  = mk(20'h00800, 1, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[9]  = mk(20'h0ffa0, 0, 1, 16'hff3a, 6'h3f, 1, 1, 0, 0);
      rows[10] = mk(20'hff000, 1, 0, 0, 6'h1f, 0, 0, 2, 0);
      rows[11] = mk(20'hfefff, 1, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[12] = mk(20'h0ffa6, 0, 1, 16'h11fe, 6'h3f, 1, 1, 0, 0);
      rows[13] = mk(20'h10000, 1, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[14] = mk(20'h0ffa8, 0, 1, 16'h0438, 6'h3f, 1, 1, 0, 0);
      rows[15] = mk(20'h10000, 1, 0, 0, 6'h3e, 0, 1, 2, 0);
      rows[16] = mk(20'h12000, 1, 0, 0, 6'h3d, 0, 1, 2, 0);
      rows[17] = mk(20'h14000, 1, 0, 0, 6'h3b, 0, 1, 2, 0);
      rows[18] = mk(20'h17fff, 1, 0, 0, 6'h37, 0, 1, 2, 0);
      rows[19] = mk(20'h18000, 1, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[20] = mk(20'h0ffff, 1, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[21] = mk(20'h0ffa2, 0, 0, 0, 6'h3f, 1, 1, 0, 16'h007d);
      rows[22] = mk(20'h007ff, 0, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[23] = mk(20'h0fffe, 0, 1, 16'h50c0, 6'h3f, 1, 1, 0, 0);
      rows[24] = mk(20'h0c0fe, 1, 0, 0, 6'h3f, 1, 1, 0, 16'h50c0);
      rows[25] = mk(20'h0fffe, 0, 0, 0, 6'h3f, 0, 0, 0, 0);
      rows[26] = mk(20'h0c010, 1, 0, 0, 6'h3f, 1, 1, 0, 16'h0000);
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      #1;
      chk("reset outs", 20'({up_n, lo_n, mid_n, internal_hit_o,
         ignore_ready_o, wait_states_o, cycle_ready_o, trap, slave}),
         20'h1f82);
      chk("reset rdata", 20'(rdata_o), 20'h0);
      foreach (rows[i]) do_row(rows[i], 20'(2 + rows[i].ws));
      chk("mode bits", 20'({slave, trap}), 20'h2);
      // slow memory: ready ignored where it must be, waited on elsewhere
      slow <= 1'b1;
      do_row(mk(20'h10000, 1, 0, 0, 6'h3e, 0, 1, 2, 0), 20'd4);
      do_row(mk(20'hff000, 1, 0, 0, 6'h1f, 0, 0, 2, 0), 20'd8);
      do_row(mk(20'h0c0a0, 1, 0, 0, 6'h3f, 1, 1, 0, 16'hff3a),
         20'd2);
      // three waits with ready ignored: a slow memory must not stretch it
      do_row(mk(20'h0c0a6, 1, 1, 16'h11ff, 6'h3f, 1, 1, 0, 0),
         20'd2);
      do_row(mk(20'h12000, 1, 0, 0, 6'h3d, 0, 1, 3, 0), 20'd5);
      slow <= 1'b0;
      // reset again in mid-run: defaults return, lower select off again
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      do_row(rows[0], 20'd2);
      do_row(rows[5], 20'd2);
      report_and_stop();
   end
endmodule
